// >>> core/pcd_decoder.sv
`timescale 1ns/1ns
module pcd_decoder
  import pcd_pkg::*;
(
  input  wire logic                  clk,           // 20 MHz clock
  input  wire logic                  rst,           // Async reset, active high
  input  wire logic                  io_valid,      // Host I/O request strobe
  input  wire pcd_pkg::pcd_io_req_t  io_req,        // Host I/O request
  input  wire logic                  cfg_done,      // Config cycle finished
  input  wire logic [31:0]           cfg_rdata,     // Config read data
  output logic                       io_ack,        // Claimed access answered
  output logic [31:0]                io_rdata,      // Read data for claimed access
  output logic                       fwd_valid,     // Forwarded I/O cycle strobe
  output pcd_pkg::pcd_io_req_t       fwd_req,       // Forwarded I/O cycle, unchanged
  output logic                       cfg_valid,     // Config cycle request
  output pcd_pkg::pcd_cfg_req_t      cfg_req,       // Config cycle target
  output logic [31:0]                cfg_addr_out   // Current address port value
);
  import pcd_pkg::*;

  typedef enum logic [1:0] {PCD_IDLE, PCD_CFG} pcd_state_t;

  pcd_state_t           state_reg, state_next;
  logic [31:0]          addr_reg, addr_next;
  logic                 ack_reg, ack_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 fwd_reg, fwd_next;
  pcd_io_req_t          fwdq_reg, fwdq_next;
  logic                 cfgv_reg, cfgv_next;
  pcd_cfg_req_t         cfgq_reg, cfgq_next;

  logic hit_addr, hit_data, dword, claim_addr, claim_data;

  always_comb begin
    hit_addr   = io_req.addr[15:2] == PCD_ADDR_PORT[15:2];
    hit_data   = io_req.addr[15:2] == PCD_DATA_PORT[15:2];
    dword      = io_req.be == PCD_BE_DWORD;
    claim_addr = hit_addr && dword;
    claim_data = hit_data && dword && addr_reg[PCD_EN_BIT];
  end

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    ack_next   = 1'b0;
    rdata_next = rdata_reg;
    fwd_next   = 1'b0;
    fwdq_next  = fwdq_reg;
    cfgv_next  = 1'b0;
    cfgq_next  = cfgq_reg;
    unique case (state_reg)
      PCD_IDLE: begin
        if (io_valid) begin
          if (claim_addr) begin
            ack_next = 1'b1;
            if (io_req.wr) begin
              addr_next = io_req.wdata & PCD_ADDR_WMASK;
            end else begin
              rdata_next = addr_reg;
            end
          end else if (claim_data) begin
            cfgv_next       = 1'b1;
            cfgq_next.bus    = addr_reg[PCD_BUS_LSB +: 8];
            cfgq_next.dev    = addr_reg[PCD_DEV_LSB +: 5];
            cfgq_next.func   = addr_reg[PCD_FUNC_LSB +: 3];
            cfgq_next.regnum = addr_reg[PCD_REG_LSB +: 6];
            cfgq_next.be     = io_req.be;
            cfgq_next.wr     = io_req.wr;
            cfgq_next.wdata  = io_req.wdata;
            state_next       = PCD_CFG;
          end else begin
            fwd_next  = 1'b1;
            fwdq_next = io_req;
          end
        end
      end
      PCD_CFG: begin
        if (cfg_done) begin
          ack_next   = 1'b1;
          rdata_next = cfgq_reg.wr ? 32'h0000_0000 : cfg_rdata;
          state_next = PCD_IDLE;
        end
      end
      default: state_next = PCD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PCD_IDLE;
      addr_reg  <= PCD_ADDR_RST;
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      fwd_reg   <= 1'b0;
      fwdq_reg  <= '0;
      cfgv_reg  <= 1'b0;
      cfgq_reg  <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      fwd_reg   <= fwd_next;
      fwdq_reg  <= fwdq_next;
      cfgv_reg  <= cfgv_next;
      cfgq_reg  <= cfgq_next;
    end
  end

  assign io_ack       = ack_reg;
  assign io_rdata     = rdata_reg;
  assign fwd_valid    = fwd_reg;
  assign fwd_req      = fwdq_reg;
  assign cfg_valid    = cfgv_reg;
  assign cfg_req      = cfgq_reg;
  assign cfg_addr_out = addr_reg;

  // Reserved and fixed address bits never read back nonzero
  property p_addr_reserved_zero;
    @(posedge clk) disable iff (rst)
      (addr_reg & ~PCD_ADDR_WMASK) == 32'h0000_0000;
  endproperty
  a_addr_reserved_zero: assert property (p_addr_reserved_zero)
    else $error("reserved address bits nonzero");

  property p_addr_write;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && hit_addr && dword && io_req.wr)
        |=> addr_reg == ($past(io_req.wdata) & PCD_ADDR_WMASK) && io_ack;
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("address port write not captured");

  property p_partial_forward;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && (hit_addr || hit_data) && !dword)
        |=> fwd_valid && fwd_req == $past(io_req) && !io_ack && !cfg_valid;
  endproperty
  a_partial_forward: assert property (p_partial_forward)
    else $error("partial access not forwarded");

  property p_partial_data_forward;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && hit_data && !dword) |=> !cfg_valid;
  endproperty
  a_partial_data_forward: assert property (p_partial_data_forward)
    else $error("partial data access claimed");

  property p_disabled_forward;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && hit_data && !addr_reg[PCD_EN_BIT])
        |=> fwd_valid && !cfg_valid;
  endproperty
  a_disabled_forward: assert property (p_disabled_forward)
    else $error("disabled data access not forwarded");

  sequence s_data_hit;
    io_valid && state_reg == PCD_IDLE && claim_data;
  endsequence

  property p_cfg_issue;
    @(posedge clk) disable iff (rst)
      s_data_hit |=> cfg_valid ##1 !cfg_valid;
  endproperty
  a_cfg_issue: assert property (p_cfg_issue)
    else $error("config cycle not issued once");

  property p_cfg_target;
    @(posedge clk) disable iff (rst)
      s_data_hit |=> cfg_req.bus == $past(addr_reg[23:16])
        && cfg_req.dev == $past(addr_reg[15:11]) && cfg_req.func == $past(addr_reg[10:8]);
  endproperty
  a_cfg_target: assert property (p_cfg_target)
    else $error("config target mismatch");

  property p_cfg_offset;
    @(posedge clk) disable iff (rst)
      s_data_hit |=> cfg_req.regnum == $past(addr_reg[7:2]) && cfg_req.be == $past(io_req.be);
  endproperty
  a_cfg_offset: assert property (p_cfg_offset)
    else $error("config offset mismatch");

  property p_data_port_hit;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && io_req.addr == 16'h0CFE) |=> !io_ack;
  endproperty
  a_data_port_hit: assert property (p_data_port_hit)
    else $error("data port acked too early");

  sequence s_cfg_end;
    state_reg == PCD_CFG && cfg_done;
  endsequence

  // Pending config cycle ends with one answer carrying the target's read data, or zero for a write
  property p_cfg_answer;
    @(posedge clk) disable iff (rst)
      s_cfg_end |=> io_ack
        && io_rdata == ($past(cfgq_reg.wr) ? 32'h0000_0000 : $past(cfg_rdata));
  endproperty
  a_cfg_answer: assert property (p_cfg_answer)
    else $error("config answer mismatch");

  property p_cfg_busy;
    @(posedge clk) disable iff (rst)
      state_reg == PCD_CFG && !cfg_done |=> !io_ack && !fwd_valid && !cfg_valid;
  endproperty
  a_cfg_busy: assert property (p_cfg_busy)
    else $error("request taken while config cycle pending");

  property p_addr_read;
    @(posedge clk) disable iff (rst)
      (io_valid && state_reg == PCD_IDLE && claim_addr && !io_req.wr)
        |=> io_ack && io_rdata == $past(addr_reg) && addr_reg == $past(addr_reg);
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("address port read mismatch");

  property p_cfg_wdata;
    @(posedge clk) disable iff (rst)
      s_data_hit |=> cfg_req.wr == $past(io_req.wr) && cfg_req.wdata == $past(io_req.wdata);
  endproperty
  a_cfg_wdata: assert property (p_cfg_wdata)
    else $error("config write data mismatch");
endmodule

// >>> core/pcd_pkg.sv
package pcd_pkg;
  localparam logic [15:0] PCD_ADDR_PORT  = 16'h0CF8;
  localparam logic [15:0] PCD_DATA_PORT  = 16'h0CFC;
  localparam int          PCD_EN_BIT     = 31;
  localparam int          PCD_BUS_LSB    = 16;
  localparam int          PCD_DEV_LSB    = 11;
  localparam int          PCD_FUNC_LSB   = 8;
  localparam int          PCD_REG_LSB    = 2;
  localparam logic [31:0] PCD_ADDR_WMASK = 32'h80FF_FFFC;
  localparam logic [31:0] PCD_ADDR_RST   = 32'h0000_0000;
  localparam logic [3:0]  PCD_BE_DWORD   = 4'hF;

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0]  be;
    logic        wr;
    logic [31:0] wdata;
  } pcd_io_req_t;

  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [5:0] regnum;
    logic [3:0] be;
    logic       wr;
    logic [31:0] wdata;
  } pcd_cfg_req_t;
endpackage

// >>> test/pcd_cfg_target.sv
`timescale 1ns/1ns
module pcd_cfg_target (
  input  wire logic        clk,    // Clock
  input  wire logic        rst,    // Reset
  input  wire logic        valid,  // Cycle request
  input  wire logic        wr,     // Cycle is a write
  input  wire logic [5:0]  regnum, // Register index
  input  wire logic [31:0] wdata,  // Write data
  input  wire logic [3:0]  delay,  // Answer delay
  input  wire logic [31:0] word,   // Read value
  output logic             done,   // Cycle done
  output logic [31:0]      rdata   // Read data
);
  // Register index 1 models a status word with write-one-to-clear bits
  localparam logic [5:0] STAT_IDX = 6'h01;
  int          cnt;
  logic        hit_stat;
  logic [31:0] stat;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt      <= 0;
      hit_stat <= 1'b0;
      stat     <= 32'hFFFF_FFFF;
      done     <= 1'b0;
      rdata    <= 32'h0;
    end else begin
      done  <= cnt == 1;
      rdata <= (cnt == 1) ? (hit_stat ? stat : word) : ~rdata;
      cnt   <= valid ? int'(delay) + 1 : (cnt > 0 ? cnt - 1 : 0);
      if (valid) begin
        hit_stat <= regnum == STAT_IDX;
        if (wr && regnum == STAT_IDX) stat <= stat & ~wdata;
      end
    end
  end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import pcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io_valid = 1'b0;
  pcd_io_req_t io_req = '0;
  logic [3:0] delay = 4'h0;
  logic [31:0] word = 32'h0;
  logic [31:0] m_addr = PCD_ADDR_RST;
  logic [31:0] m_stat = 32'hFFFF_FFFF;
  logic cfg_done, io_ack, fwd_valid, cfg_valid, seen;
  logic [31:0] cfg_rdata, io_rdata, cfg_addr_out;
  pcd_io_req_t fwd_req;
  pcd_cfg_req_t cfg_req;
  logic [15:0] ports [4] = '{PCD_ADDR_PORT, PCD_DATA_PORT, PCD_DATA_PORT, 16'h0070};
  int n_errors = 0;
  int n_checks = 0;
  pcd_decoder u_pcd_decoder (.clk(clk), .rst(rst), .io_valid(io_valid),
    .io_req(io_req), .cfg_done(cfg_done), .cfg_rdata(cfg_rdata), .io_ack(io_ack),
    .io_rdata(io_rdata), .fwd_valid(fwd_valid), .fwd_req(fwd_req),
    .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_addr_out(cfg_addr_out));
  pcd_cfg_target u_pcd_cfg_target (.clk(clk), .rst(rst), .valid(cfg_valid),
    .wr(cfg_req.wr), .regnum(cfg_req.regnum), .wdata(cfg_req.wdata),
    .delay(delay), .word(word), .done(cfg_done), .rdata(cfg_rdata));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_io(input pcd_io_req_t q);
    logic dw, ap, dp;
    pcd_cfg_req_t c;
    logic [31:0] rd;
    dw = q.be == PCD_BE_DWORD;
    ap = dw && q.addr[15:2] == PCD_ADDR_PORT[15:2];
    dp = dw && q.addr[15:2] == PCD_DATA_PORT[15:2] && m_addr[PCD_EN_BIT];
    c = '{m_addr[23:16], m_addr[15:11], m_addr[10:8], m_addr[7:2], q.be, q.wr, q.wdata};
    seen = 1'b0;
    @(posedge clk);
    io_valid <= 1'b1;
    io_req <= q;
    @(posedge clk);
    io_valid <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (cfg_valid === 1'b1) begin
        seen = 1'b1;
        `CHK("cfg_req", c, cfg_req)
      end
      if (io_ack === 1'b1 || fwd_valid === 1'b1) break;
    end
    `CHK("cfg_cycle", dp, seen)
    if (ap) begin
      if (q.wr) m_addr = q.wdata & PCD_ADDR_WMASK;
      `CHK("addr_ack", 1'b1, io_ack)
      `CHK("addr_port", m_addr, cfg_addr_out)
      if (!q.wr) `CHK("addr_read", m_addr, io_rdata)
    end else if (dp) begin
      `CHK("data_ack", 1'b1, io_ack)
      rd = (c.regnum == 6'h01) ? m_stat : word;
      `CHK("data_read", q.wr ? 32'h0 : rd, io_rdata)
      if (q.wr && c.regnum == 6'h01) m_stat = m_stat & ~q.wdata;
    end else begin
      `CHK("fwd_valid", 1'b1, fwd_valid)
      `CHK("fwd_no_ack", 1'b0, io_ack)
      `CHK("fwd_req", q, fwd_req)
    end
  endtask
  initial begin
    #(50 * 20000);
    n_errors++;
    wrap_up;
  end
  initial begin
    pcd_io_req_t q;
    void'($urandom(1));
    repeat (6) @(posedge clk);
    `CHK("rst_addr", PCD_ADDR_RST, cfg_addr_out)
    rst <= 1'b0;
    do_io('{PCD_ADDR_PORT, 4'hF, 1'b1, 32'hFFFF_FFFF});
    do_io('{PCD_ADDR_PORT, 4'hF, 1'b0, 32'h0});
    do_io('{PCD_ADDR_PORT, 4'hF, 1'b1, 32'h8000_0004});
    do_io('{PCD_DATA_PORT, 4'hF, 1'b1, 32'h0000_00F0});
    do_io('{PCD_DATA_PORT, 4'hF, 1'b0, 32'h0});
    for (int k = 0; k < 80; k++) begin
      delay <= 4'($urandom % 6);
      word <= $urandom;
      q.addr = ports[$urandom % 4] + 16'($urandom % 4);
      q.be = ($urandom % 3 != 0) ? PCD_BE_DWORD : 4'($urandom);
      q.wr = 1'($urandom);
      q.wdata = $urandom;
      do_io(q);
    end
    do_io('{PCD_ADDR_PORT, 4'hF, 1'b1, 32'h8000_0004});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("rst_mid", PCD_ADDR_RST, cfg_addr_out)
    m_addr = PCD_ADDR_RST;
    m_stat = 32'hFFFF_FFFF;
    rst <= 1'b0;
    do_io('{PCD_DATA_PORT, 4'hF, 1'b0, 32'h0});
    wrap_up;
  end
endmodule
